// file: rtl/hrs_pkg.sv
package hrs_pkg;

	////////////////////////////////////////////////////////////////
	// register map, byte addresses of aligned 32-bit words
	localparam int           NCODE         = 5;
	localparam int           IX_SHUT       = 0;
	localparam int           IX_DISOP      = 1;
	localparam int           IX_HALT       = 2;
	localparam int           IX_FAULT      = 3;
	localparam int           IX_FOLLOW     = 4;
	localparam logic [7:0]   OFS_CODE [0:4] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	localparam logic [7:0]   OFS_CTRL      = 8'h14;
	localparam logic [7:0]   OFS_MODE      = 8'h18;
	localparam logic [7:0]   OFS_FWIN      = 8'h1C;
	localparam logic [7:0]   OFS_FTMO      = 8'h20;
	localparam logic [7:0]   OFS_SCALE     = 8'h24;
	localparam logic [7:0]   OFS_SCALE_ACT = 8'h28;
	localparam logic [7:0]   OFS_STATUS    = 8'h2C;
	localparam logic [7:0]   OFS_ERRHIST   = 8'h30;
	localparam logic [7:0]   OFS_IRQ_ST    = 8'h34;
	localparam logic [7:0]   OFS_IRQ_MASK  = 8'h38;

	////////////////////////////////////////////////////////////////
	// reaction code ranges and values after reset
	localparam logic signed [15:0] CODE_MIN [0:4] = '{16'sh0000, 16'sh0000, 16'sh0001, 16'sh0000, 16'shFFFF};
	localparam logic signed [15:0] CODE_MAX [0:4] = '{16'sh0001, 16'sh0001, 16'sh0002, 16'sh0002, 16'sh0002};
	localparam logic signed [15:0] CODE_RST [0:4] = '{16'sh0001, 16'sh0001, 16'sh0001, 16'sh0002, 16'sh0002};

	////////////////////////////////////////////////////////////////
	// fields, reset values, sentinels
	localparam int           HALT_BIT     = 8;
	localparam logic [15:0]  CTRL_RST     = 16'h0000;
	localparam logic [7:0]   MODE_RST     = 8'h00;
	localparam logic [31:0]  FWIN_RST     = 32'h0000_0100;
	localparam logic [31:0]  FTMO_RST     = 32'h0000_0064;
	localparam logic [31:0]  SCALE_RST    = 32'h0000_0000;
	localparam logic [31:0]  FWIN_OFF     = 32'hFFFF_FFFF;
	localparam logic [31:0]  FTMO_OFF     = 32'h7FFF_FFFF;
	localparam logic [15:0]  FOLLOW_CODE  = 16'h0001;
	localparam int           IRQ_W        = 5;
	localparam int           IRQ_START    = 0;
	localparam int           IRQ_DONE     = 1;
	localparam int           IRQ_ERR      = 2;
	localparam int           IRQ_REJ      = 3;
	localparam int           IRQ_SCALE    = 4;
	localparam logic [4:0]   IRQ_MASK_RST = 5'h00;

	////////////////////////////////////////////////////////////////
	// operating modes in which the halt bit acts
	localparam logic [7:0]   MODE_PPOS    = 8'h01;
	localparam logic [7:0]   MODE_VEL     = 8'h02;
	localparam logic [7:0]   MODE_PVEL    = 8'h03;
	localparam logic [7:0]   MODE_PTRQ    = 8'h04;
	localparam logic [7:0]   MODE_IPOS    = 8'h07;

	typedef enum logic [1:0] {ACT_NONE = 2'b00, ACT_FREE = 2'b01, ACT_SLOW = 2'b10, ACT_QUICK = 2'b11} hrs_act_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RAMP = 2'b01, ST_HALTED = 2'b10} hrs_state_t;
	typedef enum logic [1:0] {TGT_NONE = 2'b00, TGT_READY = 2'b01, TGT_SWON = 2'b10, TGT_FAULT = 2'b11} hrs_tgt_t;

	// reaction code to stop action, common to all triggers
	function automatic hrs_act_t hrs_code_act(input logic signed [15:0] c);
		case (c)
			16'sh0000: return ACT_FREE;
			16'sh0001: return ACT_SLOW;
			16'sh0002: return ACT_QUICK;
			default:   return ACT_NONE;
		endcase
	endfunction

	function automatic logic hrs_mode_halt(input logic [7:0] m);
		return m inside {MODE_PPOS, MODE_VEL, MODE_PVEL, MODE_PTRQ, MODE_IPOS};
	endfunction

endpackage

// file: rtl/hrs_sync.sv
`timescale 1ns/100ps
module hrs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hrs_sync_st_t;

	hrs_sync_st_t r;
	hrs_sync_st_t n;

	// two stages; only the second stage reads the first
	always_comb begin
		n    = r;
		n.s1 = d;
		n.s2 = r.s1;
		if (!rst_n) begin
			n = '0;
		end
	end

	always_ff @(posedge clk) begin
		r <= n;
	end

	assign q = r.s2;
endmodule

// file: rtl/hrs_code_reg.sv
`timescale 1ns/100ps
module hrs_code_reg #(
	parameter logic signed [15:0] MINV = 16'sh0000,
	parameter logic signed [15:0] MAXV = 16'sh0001,
	parameter logic signed [15:0] RSTV = 16'sh0000
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] value,
	output logic             reject
);
	typedef struct packed {
		logic [15:0] val;
		logic        rej;
	} hrs_code_st_t;

	hrs_code_st_t r;
	hrs_code_st_t n;
	logic         ok;

	// reserved codes are refused so the last defined one stays in force
	assign ok = ($signed(wdata) >= MINV) && ($signed(wdata) <= MAXV);

	always_comb begin
		n     = r;
		n.rej = wr & ~ok; // [RL10]
		if (wr && ok) begin
			n.val = wdata;
		end
		if (!rst_n) begin
			n.val = RSTV;
			n.rej = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		r <= n;
	end

	assign value  = r.val;
	assign reject = r.rej;

	chk_reject_keeps: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
		(wr && !ok) |=> ($stable(value) && reject))
		else $error("reserved code changed the register");
	chk_accept_loads: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
		(wr && ok) |=> (value == $past(wdata) && !reject))
		else $error("defined code not stored");
endmodule

// file: rtl/hrs_top.sv
`timescale 1ns/100ps
// Overview of operation
// [RL1] Shutdown: code 0 frees the motor, code 1 ramps then ready-to-switch-on.
// [RL2] Disable operation: code 0 frees the motor, code 1 ramps then switched-on.
// [RL3] Halt bit 8 set: code 1 slow-down ramp, code 2 quick-stop ramp.
// [RL4] Halt bit acts only in the five listed operating modes.
// [RL5] Fault: code 0 free switch-off, 1 slow-down ramp, 2 quick-stop ramp.
// [RL6] Every error stores a more specific code in the error history.
// [RL7] Following error: -1 nothing, 0 free, 1 slow ramp, 2 quick ramp.
// [RL8] Window all ones or timeout maximum positive turns error monitoring off.
// [RL9] Scaling writes wait until operation-enabled is left, then take effect.
// [RL10] Reserved reaction codes are refused and the old code is kept.
// [RL11] Host writes only defined codes and sets quick-stop deceleration first.
module hrs_top
	import hrs_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        OP_ENABLED,
	input  wire logic        SHUTDOWN_REQ,
	input  wire logic        DISABLE_OP_REQ,
	input  wire logic        FAULT_EVT,
	input  wire logic [15:0] FAULT_CODE,
	input  wire logic        FOLLOW_EVT,
	input  wire logic        STANDSTILL,
	output logic             DRIVER_OFF,
	output logic             RAMP_SLOW,
	output logic             RAMP_QUICK,
	output logic             MONITOR_EN,
	output logic             STATE_GO,
	output hrs_pkg::hrs_tgt_t STATE_TGT,
	output logic      [31:0] SCALE_ACTIVE,
	output logic             IRQ
);
	import hrs_pkg::*;

	typedef struct packed {
		logic             ack;
		logic [31:0]      rdata;
		logic [15:0]      ctrl;
		logic [7:0]       mode;
		logic [31:0]      fwin;
		logic [31:0]      ftmo;
		logic [31:0]      scale_pend;
		logic [31:0]      scale_act;
		logic             scale_wait;
		hrs_state_t       st;
		hrs_act_t         act;
		hrs_tgt_t         tgt;
		logic             drv_off;
		logic             go;
		logic             mon;
		logic             halt_prev;
		logic             op_prev;
		logic [15:0]      err_hist;
		logic [7:0]       err_cnt;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
	} hrs_top_st_t;

	hrs_top_st_t      r;
	hrs_top_st_t      n;
	logic             req;
	logic             rd_take;
	logic             wr_take;
	logic [15:0]      cv [0:NCODE-1];
	logic [NCODE-1:0] rej;
	logic [NCODE-1:0] code_wr;
	logic             stand_s;
	logic             halt_rise;
	logic             follow_hit;
	logic             idle;
	hrs_act_t         t_act;
	hrs_tgt_t         t_tgt;
	logic [31:0]      rd;
	logic [IRQ_W-1:0] irq_set;

	////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, then the answer
	assign req             = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~r.ack;
	assign rd_take         = AVS_READ & r.ack;
	assign wr_take         = AVS_WRITE & r.ack;

	// the ramp end comes from the power stage pin, so it is synchronised
	hrs_sync #(
		.W (1)
	) u_stand_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     (STANDSTILL),
		.q     (stand_s)
	);

	////////////////////////////////////////////////////////////////
	// one checked register per reaction code
	genvar gi;
	generate
		for (gi = 0; gi < NCODE; gi++) begin : g_code
			assign code_wr[gi] = wr_take && (AVS_ADDRESS == OFS_CODE[gi]);
			hrs_code_reg #(
				.MINV (CODE_MIN[gi]),
				.MAXV (CODE_MAX[gi]),
				.RSTV (CODE_RST[gi])
			) u_code (
				.clk    (CLK),
				.rst_n  (RST_N),
				.wr     (code_wr[gi]),
				.wdata  (AVS_WRITEDATA[15:0]),
				.value  (cv[gi]),
				.reject (rej[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// trigger qualification
	assign idle       = (r.st == ST_IDLE);
	assign halt_rise  = r.ctrl[HALT_BIT] & ~r.halt_prev & hrs_mode_halt(r.mode) & OP_ENABLED; // [RL4]
	assign follow_hit = FOLLOW_EVT & r.mon; // [RL8]

	// fault wins over everything and may cut into a running reaction
	always_comb begin
		t_act = ACT_NONE;
		t_tgt = TGT_NONE;
		if (FAULT_EVT) begin
			t_act = hrs_code_act(cv[IX_FAULT]); // [RL5]
			t_tgt = TGT_FAULT;
		end else if (idle && follow_hit) begin
			t_act = hrs_code_act(cv[IX_FOLLOW]); // [RL7]
			t_tgt = TGT_FAULT;
		end else if (idle && OP_ENABLED && SHUTDOWN_REQ) begin
			t_act = hrs_code_act(cv[IX_SHUT]); // [RL1]
			t_tgt = TGT_READY;
		end else if (idle && OP_ENABLED && DISABLE_OP_REQ) begin
			t_act = hrs_code_act(cv[IX_DISOP]); // [RL2]
			t_tgt = TGT_SWON;
		end else if (idle && halt_rise) begin
			t_act = hrs_code_act(cv[IX_HALT]); // [RL3]
			t_tgt = TGT_NONE;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux, registered one cycle before the answer
	always_comb begin
		rd = 32'h0000_0000;
		for (int i = 0; i < NCODE; i++) begin
			if (AVS_ADDRESS == OFS_CODE[i]) begin
				rd = {{16{cv[i][15]}}, cv[i]};
			end
		end
		if (AVS_ADDRESS == OFS_CTRL) begin
			rd = {16'h0000, r.ctrl};
		end else if (AVS_ADDRESS == OFS_MODE) begin
			rd = {24'h00_0000, r.mode};
		end else if (AVS_ADDRESS == OFS_FWIN) begin
			rd = r.fwin;
		end else if (AVS_ADDRESS == OFS_FTMO) begin
			rd = r.ftmo;
		end else if (AVS_ADDRESS == OFS_SCALE) begin
			rd = r.scale_pend;
		end else if (AVS_ADDRESS == OFS_SCALE_ACT) begin
			rd = r.scale_act;
		end else if (AVS_ADDRESS == OFS_STATUS) begin
			rd = {13'h0000, r.st, r.act, r.tgt, r.drv_off, r.mon, r.scale_wait, 2'b00, r.err_cnt};
		end else if (AVS_ADDRESS == OFS_ERRHIST) begin
			rd = {16'h0000, r.err_hist};
		end else if (AVS_ADDRESS == OFS_IRQ_ST) begin
			rd = {27'h000_0000, r.irq_st};
		end else if (AVS_ADDRESS == OFS_IRQ_MASK) begin
			rd = {27'h000_0000, r.irq_mask};
		end
	end

	////////////////////////////////////////////////////////////////
	// next state of the whole block
	always_comb begin
		n       = r;
		n.go    = 1'b0;
		irq_set = '0;
		n.ack   = req & ~r.ack;
		if (req && !r.ack) begin
			n.rdata = rd;
		end

		// pending scaling goes live once operation-enabled is left
		if (!OP_ENABLED && r.scale_wait) begin
			n.scale_act       = r.scale_pend; // [RL9]
			n.scale_wait      = 1'b0;
			irq_set[IRQ_SCALE] = 1'b1;
		end

		// register writes; applied after the scaling step so none is lost
		if (wr_take) begin
			if (AVS_ADDRESS == OFS_CTRL) begin
				n.ctrl = AVS_WRITEDATA[15:0];
			end else if (AVS_ADDRESS == OFS_MODE) begin
				n.mode = AVS_WRITEDATA[7:0];
			end else if (AVS_ADDRESS == OFS_FWIN) begin
				n.fwin = AVS_WRITEDATA;
			end else if (AVS_ADDRESS == OFS_FTMO) begin
				n.ftmo = AVS_WRITEDATA;
			end else if (AVS_ADDRESS == OFS_SCALE) begin
				n.scale_pend = AVS_WRITEDATA;
				n.scale_wait = 1'b1; // [RL9]
			end else if (AVS_ADDRESS == OFS_IRQ_MASK) begin
				n.irq_mask = AVS_WRITEDATA[IRQ_W-1:0];
			end
		end

		// sentinel thresholds switch monitoring off
		n.mon       = !((r.fwin == FWIN_OFF) || (r.ftmo == FTMO_OFF)); // [RL8]
		n.halt_prev = r.ctrl[HALT_BIT];
		n.op_prev   = OP_ENABLED;

		// driver comes back only when operation is enabled again
		if (OP_ENABLED && !r.op_prev) begin
			n.drv_off = 1'b0;
		end

		// reaction sequencer
		case (r.st)
			ST_IDLE: begin
				n.st = ST_IDLE;
			end
			ST_RAMP: begin
				if (stand_s) begin
					n.go              = (r.tgt != TGT_NONE); // [RL1] [RL2]
					irq_set[IRQ_DONE] = 1'b1;
					if (r.tgt == TGT_NONE && r.ctrl[HALT_BIT]) begin
						n.st = ST_HALTED;
					end else begin
						n.st = ST_IDLE;
					end
				end
			end
			ST_HALTED: begin
				if (!r.ctrl[HALT_BIT]) begin
					n.st = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// a new reaction overrides the sequencer step above
		if (t_act == ACT_FREE) begin
			n.drv_off          = 1'b1; // [RL1] [RL2] [RL5] [RL7]
			n.go               = (t_tgt != TGT_NONE);
			n.tgt              = t_tgt;
			n.act              = ACT_FREE;
			n.st               = ST_IDLE;
			irq_set[IRQ_START] = 1'b1;
			irq_set[IRQ_DONE]  = 1'b1;
		end else if (t_act != ACT_NONE) begin
			n.st               = ST_RAMP; // [RL3] [RL5] [RL7]
			n.act              = t_act;
			n.tgt              = t_tgt;
			irq_set[IRQ_START] = 1'b1;
		end

		// error history; a fault outranks a same-cycle following error
		if (FAULT_EVT) begin
			n.err_hist       = FAULT_CODE; // [RL6]
			n.err_cnt        = r.err_cnt + 8'h01;
			irq_set[IRQ_ERR] = 1'b1;
		end else if (follow_hit) begin
			n.err_hist       = FOLLOW_CODE; // [RL6]
			n.err_cnt        = r.err_cnt + 8'h01;
			irq_set[IRQ_ERR] = 1'b1;
		end
		irq_set[IRQ_REJ] = |rej;

		// read clears status; a new event in that cycle survives
		if (rd_take && AVS_ADDRESS == OFS_IRQ_ST) begin
			n.irq_st = irq_set;
		end else begin
			n.irq_st = r.irq_st | irq_set;
		end

		if (!RST_N) begin
			n            = '0;
			n.ctrl       = CTRL_RST;
			n.mode       = MODE_RST;
			n.fwin       = FWIN_RST;
			n.ftmo       = FTMO_RST;
			n.scale_pend = SCALE_RST;
			n.scale_act  = SCALE_RST;
			n.irq_mask   = IRQ_MASK_RST;
		end
	end

	always_ff @(posedge CLK) begin
		r <= n;
	end

	////////////////////////////////////////////////////////////////
	// outputs, all from flops except the handshake
	assign AVS_READDATA = r.rdata;
	assign DRIVER_OFF   = r.drv_off;
	assign RAMP_SLOW    = (r.st != ST_IDLE) && (r.act == ACT_SLOW);
	assign RAMP_QUICK   = (r.st != ST_IDLE) && (r.act == ACT_QUICK);
	assign MONITOR_EN   = r.mon;
	assign STATE_GO     = r.go;
	assign STATE_TGT    = r.tgt;
	assign SCALE_ACTIVE = r.scale_act;
	assign IRQ          = |(r.irq_st & r.irq_mask);

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence s_op_held;
		OP_ENABLED ##1 OP_ENABLED;
	endsequence

	sequence s_ramp_done(hrs_tgt_t tg);
		(r.st == ST_RAMP) && (r.tgt == tg) && stand_s && !FAULT_EVT;
	endsequence

	chk_bus_one_wait: assert property (
		(req && !r.ack) |=> (!AVS_WAITREQUEST && r.ack))
		else $error("bus answer not after one wait cycle");
	chk_shut_ramp: assert property ( // [RL1]
		(idle && OP_ENABLED && SHUTDOWN_REQ && !FAULT_EVT && !follow_hit
			&& $signed(cv[IX_SHUT]) == 16'sh0001) |=> (RAMP_SLOW && STATE_TGT == TGT_READY))
		else $error("shutdown code 1 did not start slow ramp");
	chk_disop_target: assert property ( // [RL2]
		s_ramp_done(TGT_SWON) |=> (STATE_GO && STATE_TGT == TGT_SWON && !RAMP_SLOW && !RAMP_QUICK))
		else $error("disable operation ramp did not end in switched on");
	chk_halt_quick: assert property ( // [RL3]
		(idle && halt_rise && !FAULT_EVT && !follow_hit && !SHUTDOWN_REQ && !DISABLE_OP_REQ
			&& $signed(cv[IX_HALT]) == 16'sh0002) |=> (RAMP_QUICK && !STATE_GO))
		else $error("halt code 2 did not start quick ramp");
	chk_halt_mode: assert property ( // [RL4]
		(idle && !hrs_mode_halt(r.mode) && !FAULT_EVT && !follow_hit
			&& !(OP_ENABLED && (SHUTDOWN_REQ || DISABLE_OP_REQ))) |=> (r.st == ST_IDLE))
		else $error("halt acted outside its modes");
	chk_fault_free: assert property ( // [RL5]
		(FAULT_EVT && $signed(cv[IX_FAULT]) == 16'sh0000) |=> (DRIVER_OFF && STATE_GO
			&& STATE_TGT == TGT_FAULT) ##1 DRIVER_OFF [*2])
		else $error("fault code 0 did not cut the driver");
	chk_err_record: assert property ( // [RL6]
		FAULT_EVT |=> (r.err_hist == $past(FAULT_CODE) && r.err_cnt == $past(r.err_cnt) + 8'h01))
		else $error("fault code not recorded");
	chk_follow_none: assert property ( // [RL7]
		(idle && follow_hit && !FAULT_EVT && $signed(cv[IX_FOLLOW]) == 16'shFFFF)
			|=> (r.st == ST_IDLE && r.err_hist == FOLLOW_CODE))
		else $error("following error code -1 caused a reaction");
	chk_monitor_off: assert property ( // [RL8]
		(r.fwin == FWIN_OFF || r.ftmo == FTMO_OFF) |=> !MONITOR_EN)
		else $error("monitoring left on at sentinel value");
	chk_scale_hold: assert property ( // [RL9]
		s_op_held |-> $stable(SCALE_ACTIVE))
		else $error("scaling changed in operation enabled");
endmodule

// file: verification/hrs_stage_model.sv
`timescale 1ns/100ps
module hrs_stage_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ramp_slow,
	input  wire logic       ramp_quick,
	input  wire logic [3:0] lag,
	output logic            standstill
);
	logic [3:0] cnt_q;

	////////////////////////////////////////////////////////////////
	// braking takes lag+1 cycles before the axis reports standstill;
	// with no ramp commanded the pin reads low, so a stale standstill never ends a new ramp early
	always @(posedge clk) begin
		if (!rst_n || !(ramp_slow || ramp_quick)) begin
			cnt_q      <= 4'h0;
			standstill <= 1'b0;
		end else if (cnt_q >= lag) begin
			standstill <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import hrs_pkg::*;
	logic        CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, OP_ENABLED, SHUTDOWN_REQ, DISABLE_OP_REQ;
	logic        FAULT_EVT, FOLLOW_EVT, STANDSTILL, DRIVER_OFF, RAMP_SLOW, RAMP_QUICK, MONITOR_EN, STATE_GO, IRQ;
	logic [7:0]  AVS_ADDRESS;
	logic [15:0] FAULT_CODE;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, SCALE_ACTIVE;
	logic [3:0]  lag;
	hrs_tgt_t    STATE_TGT;
	int          mismatches, n_checks, cycles;

	hrs_top uut (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.OP_ENABLED(OP_ENABLED), .SHUTDOWN_REQ(SHUTDOWN_REQ), .DISABLE_OP_REQ(DISABLE_OP_REQ),
		.FAULT_EVT(FAULT_EVT), .FAULT_CODE(FAULT_CODE), .FOLLOW_EVT(FOLLOW_EVT), .STANDSTILL(STANDSTILL),
		.DRIVER_OFF(DRIVER_OFF), .RAMP_SLOW(RAMP_SLOW), .RAMP_QUICK(RAMP_QUICK), .MONITOR_EN(MONITOR_EN),
		.STATE_GO(STATE_GO), .STATE_TGT(STATE_TGT), .SCALE_ACTIVE(SCALE_ACTIVE), .IRQ(IRQ));

	hrs_stage_model stage (.clk(CLK), .rst_n(RST_N), .ramp_slow(RAMP_SLOW), .ramp_quick(RAMP_QUICK),
		.lag(lag), .standstill(STANDSTILL));

	////////////////////////////////////////////////////////////////
	// clock and hang guard; the whole run needs well under 3000 cycles
	always #50 CLK = ~CLK;
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report;
		if (mismatches == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// bus master: hold the request until waitrequest is sampled low, the leading edge keeps drivers apart
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE     <= 1'b1;
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_READ    <= 1'b1;
		do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ <= 1'b0;
	endtask

	// one-cycle trigger pulse; outputs are looked at in the cycle after it
	task automatic fire(input int k);
		@(posedge CLK);
		SHUTDOWN_REQ   <= (k == IX_SHUT);
		DISABLE_OP_REQ <= (k == IX_DISOP);
		FAULT_EVT      <= (k == IX_FAULT);
		FOLLOW_EVT     <= (k == IX_FOLLOW);
		@(posedge CLK);
		{SHUTDOWN_REQ, DISABLE_OP_REQ, FAULT_EVT, FOLLOW_EVT} <= 4'h0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	// reset codes, reserved codes refused, interrupt masking and read-clear, unmapped places
	task automatic t_codes;
		logic [31:0] d;
		bus_rd(OFS_IRQ_MASK, d);
		check(d, {27'h0, IRQ_MASK_RST});
		for (int i = 0; i < NCODE; i++) begin
			bus_wr(OFS_CODE[i], {16'h0000, CODE_MAX[i] + 16'sh0001});
			bus_wr(OFS_CODE[i], {16'h0000, CODE_MIN[i] - 16'sh0001});
			bus_rd(OFS_CODE[i], d);
			check(d, {{16{CODE_RST[i][15]}}, CODE_RST[i]});
			check(IRQ, 1'b0);
		end
		bus_wr(OFS_IRQ_MASK, 32'h0000_0008);
		#1 check(IRQ, 1'b1);
		bus_rd(OFS_IRQ_ST, d);
		check(d & 32'h8, 32'h8);
		#1 check(IRQ, 1'b0);
		bus_wr(8'h3C, 32'hFFFF_FFFF);
		bus_rd(8'h3C, d);
		check(d, 32'h0);
		bus_rd(8'h01, d);
		check(d, 32'h0);
		bus_wr(OFS_IRQ_MASK, 32'h0);
	endtask

	// scaling written while operation is enabled waits until it is left
	task automatic t_scale;
		bus_wr(OFS_SCALE, 32'h0001_2345);
		repeat (4) @(posedge CLK);
		#1 check(SCALE_ACTIVE, SCALE_RST);
		@(posedge CLK);
		OP_ENABLED <= 1'b0;
		repeat (3) @(posedge CLK);
		#1 check(SCALE_ACTIVE, 32'h0001_2345);
		bus_wr(OFS_SCALE, 32'h0000_00C8);
		repeat (2) @(posedge CLK);
		#1 check(SCALE_ACTIVE, 32'h0000_00C8);
		@(posedge CLK);
		OP_ENABLED <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	// one trigger with one reaction code; odd codes meet a slow stage, even a prompt one
	task automatic react(input int k, input logic [15:0] code, input hrs_tgt_t tgt);
		logic [31:0] d;
		logic        fr, sl, qk;
		int          n;
		fr = (code == 16'h0000);
		sl = (code == 16'h0001);
		qk = (code == 16'h0002);
		n  = 0;
		@(posedge CLK);
		lag        <= code[0] ? 4'h9 : 4'h1;
		FAULT_CODE <= 16'h5A00 | code;
		bus_wr(OFS_CODE[k], {16'h0000, code});
		if (k == IX_HALT) begin
			bus_wr(OFS_CTRL, 32'h0000_0100);
			#1;
			while (n < 3 && !(RAMP_SLOW || RAMP_QUICK)) begin
				@(posedge CLK);
				#1;
				n++;
			end
		end else begin
			fire(k);
		end
		check({DRIVER_OFF, RAMP_SLOW, RAMP_QUICK, STATE_GO}, {fr, sl, qk, fr});
		if (fr) begin
			check(STATE_TGT, tgt);
			@(posedge CLK);
			OP_ENABLED <= 1'b0;
			@(posedge CLK);
			OP_ENABLED <= 1'b1;
			#1 check(DRIVER_OFF, 1'b1);
			repeat (2) @(posedge CLK);
			#1 check(DRIVER_OFF, 1'b0);
		end
		if (sl || qk) begin
			if (k == IX_HALT) begin
				repeat (16) @(posedge CLK);
				#1 check({RAMP_SLOW, RAMP_QUICK, STATE_GO}, {sl, qk, 1'b0});
				bus_wr(OFS_CTRL, 32'h0);
				#1;
			end
			n = 0;
			while (RAMP_SLOW || RAMP_QUICK) begin
				@(posedge CLK);
				#1;
				n++;
			end
			check(STATE_GO, k != IX_HALT);
			if (k != IX_HALT) begin
				check(STATE_TGT, tgt);
				check(n > lag, 1'b1); // ramp waits for the stage's standstill
			end
		end
		if (k == IX_FAULT || k == IX_FOLLOW) begin
			bus_rd(OFS_ERRHIST, d);
			check(d[15:0], (k == IX_FAULT) ? (16'h5A00 | code) : FOLLOW_CODE);
		end
	endtask

	// halt acts in the five listed modes only
	task automatic t_halt;
		logic [7:0] good [5] = '{MODE_PPOS, MODE_VEL, MODE_PVEL, MODE_PTRQ, MODE_IPOS};
		logic [7:0] bad [4]  = '{8'h00, 8'h05, 8'h06, 8'h08};
		foreach (good[i]) begin
			bus_wr(OFS_MODE, {24'h0, good[i]});
			react(IX_HALT, 16'(1 + i % 2), TGT_NONE);
		end
		foreach (bad[i]) begin
			bus_wr(OFS_MODE, {24'h0, bad[i]});
			bus_wr(OFS_CTRL, 32'h0000_0100);
			repeat (3) @(posedge CLK);
			#1 check({RAMP_SLOW, RAMP_QUICK}, 2'b00);
			bus_wr(OFS_CTRL, 32'h0);
		end
	endtask

	// sentinel thresholds switch monitoring off, one below them does not
	task automatic t_monitor;
		logic [7:0]  a [2]   = '{OFS_FWIN, OFS_FTMO};
		logic [31:0] off [2] = '{FWIN_OFF, FTMO_OFF};
		logic [31:0] rv [2]  = '{FWIN_RST, FTMO_RST};
		logic [31:0] d;
		for (int i = 0; i < 2; i++) begin
			bus_wr(a[i], off[i] - 32'h1);
			repeat (2) @(posedge CLK);
			#1 check(MONITOR_EN, 1'b1);
			bus_wr(a[i], off[i]);
			repeat (2) @(posedge CLK);
			#1 check(MONITOR_EN, 1'b0);
			// status fields: idle, last halt left a slow action, no target, driver on, monitor off
			bus_rd(OFS_STATUS, d);
			check(d[18:10], {2'b00, ACT_SLOW, TGT_NONE, 3'b000});
			fire(IX_FOLLOW);
			check({DRIVER_OFF, RAMP_SLOW, RAMP_QUICK}, 3'b000);
			bus_wr(a[i], rv[i]);
		end
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{CLK, RST_N, AVS_READ, AVS_WRITE, SHUTDOWN_REQ, DISABLE_OP_REQ, FAULT_EVT, FOLLOW_EVT} = 8'h00;
		{AVS_ADDRESS, FAULT_CODE, AVS_WRITEDATA} = 56'h0;
		OP_ENABLED = 1'b1;
		lag = 4'h1;
		{mismatches, n_checks, cycles} = '0;
		repeat (5) @(posedge CLK);
		RST_N <= 1'b1;
		t_codes();
		t_scale();
		for (int c = 0; c < 2; c++) begin
			react(IX_SHUT, 16'(c), TGT_READY);
			react(IX_DISOP, 16'(c), TGT_SWON);
		end
		for (int c = 0; c < 3; c++) begin
			react(IX_FAULT, 16'(c), TGT_FAULT);
		end
		for (int c = -1; c < 3; c++) begin
			react(IX_FOLLOW, 16'(c), TGT_FAULT);
		end
		t_halt();
		t_monitor();
		final_report();
	end
endmodule
